/* File: hdl/flash_bus_if.sv */
interface flash_bus_if;
    logic start;
    logic is_read;
    logic [7:0] wdata;
    logic [flash_seq_pkg::ADDR_W-1:0] addr;
    logic done;
    logic [7:0] rdata;
    modport master(output start, output is_read, output wdata, output addr, input done, input rdata);
    modport engine(input start, input is_read, input wdata, input addr, output done, output rdata);
endinterface

/* File: hdl/flash_erase_unlock_sequencer.sv */
module flash_erase_unlock_sequencer (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [flash_seq_pkg::ADDR_W-1:0] flash_addr,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i,
    output logic power_down_reset_pin_n,
    input wire logic completion_indicator
);
    flash_bus_if bus();
    logic ce_w, oe_w, we_w, dqoe_w;
    logic [7:0] dqo_w;
    logic [flash_seq_pkg::ADDR_W-1:0] fa_w;
    flash_strobe_engine u_eng (
        .pclk(pclk),
        .presetn(presetn),
        .bus(bus),
        .ce_n_r(ce_w),
        .oe_n_r(oe_w),
        .we_n_r(we_w),
        .fa_r(fa_w),
        .dq_o_r(dqo_w),
        .dq_oe_r(dqoe_w),
        .dq_i(flash_dq_i)
    );
    assign flash_ce_n = ce_w;
    assign flash_oe_n = oe_w;
    assign flash_we_n = we_w;
    assign flash_addr = fa_w;
    assign flash_dq_o = dqo_w;
    assign flash_dq_oe = dqoe_w;

    flash_seq_pkg::seq_state_t st_r, st_nxt;
    logic [7:0] setup_r, setup_nxt, status_r, status_nxt;
    logic [flash_seq_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic busy_r, busy_nxt, start_r, start_nxt, pd_r, pd_nxt, ind_r, ind_q_r;
    logic [flash_seq_pkg::IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
    logic [31:0] prdata_nxt;
    logic wr_acc, rd_acc, pready_r;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign bus.start = start_r;
    assign bus.is_read = (st_r == flash_seq_pkg::ST_RD_STATUS);
    assign bus.addr = addr_r;
    always_comb begin
        case (st_r)
            flash_seq_pkg::ST_WR_SETUP: bus.wdata = setup_r;
            flash_seq_pkg::ST_WR_CONFIRM: bus.wdata = flash_seq_pkg::CMD_CONFIRM;
            flash_seq_pkg::ST_WR_POLLCMD: bus.wdata = flash_seq_pkg::CMD_READ_STATUS;
            flash_seq_pkg::ST_WR_CLEAR: bus.wdata = flash_seq_pkg::CMD_CLEAR_STATUS;
            flash_seq_pkg::ST_WR_ARRAY: bus.wdata = flash_seq_pkg::CMD_READ_ARRAY;
            default: bus.wdata = 8'h00;
        endcase
    end

    function automatic logic seq_error(input logic [7:0] s);
        seq_error = s[flash_seq_pkg::ERASE_ERR_BIT] && s[flash_seq_pkg::PROG_ERR_BIT];
    endfunction

    // sequence control
    always_comb begin
        st_nxt = st_r;
        setup_nxt = setup_r;
        addr_nxt = addr_r;
        status_nxt = status_r;
        busy_nxt = busy_r;
        pd_nxt = pd_r;
        start_nxt = 1'b0;
        ev = '0;
        ev[flash_seq_pkg::IRQ_INDICATOR] = ind_q_r && !ind_r;
        if (wr_acc && paddr == flash_seq_pkg::REG_ADDR && !busy_r) begin
            addr_nxt = pwdata[flash_seq_pkg::ADDR_W-1:0];
        end
        if (wr_acc && paddr == flash_seq_pkg::REG_CTRL) begin
            pd_nxt = pwdata[flash_seq_pkg::CTRL_PD];
        end
        case (st_r)
            flash_seq_pkg::ST_IDLE: begin
                busy_nxt = 1'b0;
                if (wr_acc && paddr == flash_seq_pkg::REG_CTRL && !pwdata[flash_seq_pkg::CTRL_PD]) begin
                    if (pwdata[flash_seq_pkg::CTRL_GO_ERASE]) begin
                        setup_nxt = flash_seq_pkg::CMD_ERASE_SETUP;
                        st_nxt = flash_seq_pkg::ST_WR_SETUP;
                    end else if (pwdata[flash_seq_pkg::CTRL_GO_UNLOCK]) begin
                        setup_nxt = flash_seq_pkg::CMD_LOCK_CLEAR_SETUP;
                        st_nxt = flash_seq_pkg::ST_WR_SETUP;
                    end else if (pwdata[flash_seq_pkg::CTRL_GO_POLL]) begin
                        st_nxt = flash_seq_pkg::ST_WR_POLLCMD;
                    end
                    if (pwdata[2:0] != 3'h0) begin
                        busy_nxt = 1'b1;
                        start_nxt = 1'b1;
                    end
                end
            end
            flash_seq_pkg::ST_WR_SETUP: if (bus.done) begin
                st_nxt = flash_seq_pkg::ST_WR_CONFIRM;
                start_nxt = 1'b1;
            end
            flash_seq_pkg::ST_WR_CONFIRM: if (bus.done) begin
                st_nxt = flash_seq_pkg::ST_WR_POLLCMD;
                start_nxt = 1'b1;
            end
            flash_seq_pkg::ST_WR_POLLCMD: if (bus.done) begin
                st_nxt = flash_seq_pkg::ST_RD_STATUS;
                start_nxt = 1'b1;
            end
            flash_seq_pkg::ST_RD_STATUS: if (bus.done) begin
                start_nxt = 1'b1;
                // low bits meaningless while busy, so only keep a ready snapshot
                if (bus.rdata[flash_seq_pkg::READY_BIT]) begin
                    status_nxt = bus.rdata;
                    ev[flash_seq_pkg::IRQ_DONE] = 1'b1;
                    ev[flash_seq_pkg::IRQ_SEQ] = seq_error(bus.rdata);
                    ev[flash_seq_pkg::IRQ_ERROR] = |{bus.rdata[flash_seq_pkg::ERASE_ERR_BIT],
                        bus.rdata[flash_seq_pkg::VPP_ERR_BIT], bus.rdata[flash_seq_pkg::PROTECT_BIT]};
                    // clear whenever any of bits 6:0 is set; a clean run goes straight to read array
                    st_nxt = (|bus.rdata[6:0]) ? flash_seq_pkg::ST_WR_CLEAR : flash_seq_pkg::ST_WR_ARRAY;
                end else begin
                    status_nxt = {1'b0, status_r[6:0]};
                end
            end
            flash_seq_pkg::ST_WR_CLEAR: if (bus.done) begin
                st_nxt = flash_seq_pkg::ST_WR_ARRAY;
                start_nxt = 1'b1;
            end
            flash_seq_pkg::ST_WR_ARRAY: if (bus.done) begin
                st_nxt = flash_seq_pkg::ST_IDLE;
            end
            default: st_nxt = flash_seq_pkg::ST_IDLE;
        endcase
        // pulling the pin low aborts the device and its status, so drop our sequence too
        if (pd_r) begin
            st_nxt = flash_seq_pkg::ST_IDLE;
            start_nxt = 1'b0;
            busy_nxt = 1'b0;
            status_nxt = 8'h00;
        end
    end

    // interrupt status, set wins over clear
    always_comb begin
        imask_nxt = imask_r;
        ist_nxt = ist_r;
        if (wr_acc && paddr == flash_seq_pkg::REG_IRQ_MASK) begin
            imask_nxt = pwdata[flash_seq_pkg::IRQ_W-1:0];
        end
        if (wr_acc && paddr == flash_seq_pkg::REG_IRQ_STATUS) begin
            ist_nxt = ist_r & ~pwdata[flash_seq_pkg::IRQ_W-1:0];
        end
        ist_nxt = ist_nxt | ev;
    end

    always_comb begin
        prdata_nxt = prdata;
        if (rd_acc) begin
            case (paddr)
                flash_seq_pkg::REG_CTRL: prdata_nxt = {27'h0, busy_r, pd_r, 3'h0};
                flash_seq_pkg::REG_ADDR: prdata_nxt = {10'h0, addr_r};
                flash_seq_pkg::REG_STATUS: prdata_nxt = {23'h0, completion_indicator, status_r};
                flash_seq_pkg::REG_IRQ_STATUS: prdata_nxt = {28'h0, ist_r};
                flash_seq_pkg::REG_IRQ_MASK: prdata_nxt = {28'h0, imask_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= flash_seq_pkg::ST_IDLE;
            setup_r <= 8'h00;
            addr_r <= '0;
            status_r <= 8'h00;
            busy_r <= 1'b0;
            start_r <= 1'b0;
            pd_r <= 1'b0;
            ind_r <= 1'b1;
            ind_q_r <= 1'b1;
            ist_r <= '0;
            imask_r <= '0;
            prdata <= 32'h0;
            pready_r <= 1'b0;
            irq <= 1'b0;
            power_down_reset_pin_n <= 1'b0;
        end else begin
            st_r <= st_nxt;
            setup_r <= setup_nxt;
            addr_r <= addr_nxt;
            status_r <= status_nxt;
            busy_r <= busy_nxt;
            start_r <= start_nxt;
            pd_r <= pd_nxt;
            // indicator pulled up when floating, so high is idle or suspended
            ind_r <= completion_indicator;
            ind_q_r <= ind_r;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            prdata <= prdata_nxt;
            pready_r <= psel && !penable;
            irq <= |(ist_nxt & imask_nxt);
            power_down_reset_pin_n <= !pd_nxt;
        end
    end
    assign pready = pready_r;
    assign pslverr = 1'b0;

    confirm_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_WR_SETUP && bus.done && !pd_r |=> st_r == flash_seq_pkg::ST_WR_CONFIRM)
        else $error("confirm did not follow setup");
    poll_then_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_WR_POLLCMD && bus.done && !pd_r |=> st_r == flash_seq_pkg::ST_RD_STATUS)
        else $error("status read did not follow poll command");
    busy_keeps_poll_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_RD_STATUS && bus.done && !bus.rdata[7] && !pd_r
        |=> st_r == flash_seq_pkg::ST_RD_STATUS) else $error("left polling while busy");
    seq_err_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_RD_STATUS && bus.done && bus.rdata[7] && bus.rdata[5] && bus.rdata[4]
        |=> ist_r[flash_seq_pkg::IRQ_SEQ]) else $error("sequence error not flagged");
    error_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_RD_STATUS && bus.done && bus.rdata[7] && bus.rdata[5] && !pd_r
        |=> st_r == flash_seq_pkg::ST_WR_CLEAR) else $error("error not cleared");
    array_last_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_WR_ARRAY && bus.done |=> st_r == flash_seq_pkg::ST_IDLE)
        else $error("read array not last");
    pd_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
        pd_r |=> st_r == flash_seq_pkg::ST_IDLE && status_r == 8'h00) else $error("power-down did not abort");
    pin_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pd_r) |-> !power_down_reset_pin_n) else $error("pin not driven low");
    ind_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        ind_q_r && !ind_r |=> ist_r[flash_seq_pkg::IRQ_INDICATOR]) else $error("indicator edge lost");
    erase_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_WR_SETUP && setup_r == flash_seq_pkg::CMD_ERASE_SETUP);
    unlock_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == flash_seq_pkg::ST_WR_SETUP && setup_r == flash_seq_pkg::CMD_LOCK_CLEAR_SETUP);
    clear_cov_c: cover property (@(posedge pclk) disable iff (!presetn) st_r == flash_seq_pkg::ST_WR_CLEAR);
endmodule

/* File: hdl/flash_seq_pkg.sv */
package flash_seq_pkg;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_LOCK_CLEAR_SETUP = 8'h60;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam int READY_BIT = 7;
    localparam int ERASE_ERR_BIT = 5;
    localparam int PROG_ERR_BIT = 4;
    localparam int VPP_ERR_BIT = 3;
    localparam int PROTECT_BIT = 1;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] REG_IRQ_MASK = 12'h010;
    localparam int CTRL_GO_ERASE = 0;
    localparam int CTRL_GO_UNLOCK = 1;
    localparam int CTRL_GO_POLL = 2;
    localparam int CTRL_PD = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_SEQ = 2;
    localparam int IRQ_INDICATOR = 3;
    localparam int IRQ_W = 4;
    localparam int STROBE_NS = 200;
    localparam int CLK_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_W = 22;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_WR_SETUP = 7'h02,
        ST_WR_CONFIRM = 7'h04,
        ST_WR_POLLCMD = 7'h08,
        ST_RD_STATUS = 7'h10,
        ST_WR_CLEAR = 7'h20,
        ST_WR_ARRAY = 7'h40
    } seq_state_t;
endpackage

/* File: hdl/flash_strobe_engine.sv */
// one bus cycle on the flash pins, timed by a cycle counter
module flash_strobe_engine (
    input wire logic pclk,
    input wire logic presetn,
    flash_bus_if.engine bus,
    // flash pins
    output logic ce_n_r,
    output logic oe_n_r,
    output logic we_n_r,
    output logic [flash_seq_pkg::ADDR_W-1:0] fa_r,
    output logic [7:0] dq_o_r,
    output logic dq_oe_r,
    input wire logic [7:0] dq_i
);
    logic [3:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt, rd_r, rd_nxt, done_r, done_nxt;
    logic ce_nxt, oe_nxt, we_nxt, dqoe_nxt;
    logic [7:0] do_nxt, rdata_r, rdata_nxt;
    logic [flash_seq_pkg::ADDR_W-1:0] fa_nxt;
    assign bus.done = done_r;
    assign bus.rdata = rdata_r;
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        rd_nxt = rd_r;
        done_nxt = 1'b0;
        ce_nxt = ce_n_r;
        oe_nxt = oe_n_r;
        we_nxt = we_n_r;
        dqoe_nxt = dq_oe_r;
        do_nxt = dq_o_r;
        fa_nxt = fa_r;
        rdata_nxt = rdata_r;
        if (!busy_r && bus.start) begin
            busy_nxt = 1'b1;
            rd_nxt = bus.is_read;
            cnt_nxt = 4'(flash_seq_pkg::STROBE_CYC);
            fa_nxt = bus.addr;
            do_nxt = bus.wdata;
            dqoe_nxt = !bus.is_read;
            ce_nxt = 1'b0;
            oe_nxt = !bus.is_read;
            we_nxt = bus.is_read;
        end else if (busy_r) begin
            if (cnt_r != 4'h0) begin
                cnt_nxt = cnt_r - 4'h1;
            end else if (!we_n_r || !oe_n_r) begin
                // strobe rises first; data, address and chip-enable held past the latching edge
                if (rd_r) begin
                    rdata_nxt = dq_i;
                end
                oe_nxt = 1'b1;
                we_nxt = 1'b1;
            end else begin
                ce_nxt = 1'b1;
                dqoe_nxt = 1'b0;
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            rd_r <= 1'b0;
            done_r <= 1'b0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            dq_oe_r <= 1'b0;
            dq_o_r <= 8'h00;
            fa_r <= '0;
            rdata_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            rd_r <= rd_nxt;
            done_r <= done_nxt;
            ce_n_r <= ce_nxt;
            oe_n_r <= oe_nxt;
            we_n_r <= we_nxt;
            dq_oe_r <= dqoe_nxt;
            dq_o_r <= do_nxt;
            fa_r <= fa_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    strobe_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(we_n_r) |-> !we_n_r [*3]) else $error("write strobe too short");
endmodule

/* File: verif/flash_device_model.sv */
module flash_device_model (
    // time base for the busy period
    input wire logic pclk,
    // device pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [21:0] addr,
    input wire logic [7:0] dq_wr,
    input wire logic dq_wr_en,
    input wire logic rp_n,
    output logic [7:0] dq_rd,
    output logic ind,
    // fault applied at the next confirm
    input wire logic [2:0] inj
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BUSY_CYC = 40;
    logic [7:0] flags = 8'h00;
    logic [7:0] prev_cmd = 8'hFF;
    logic [7:0] drv;
    logic [7:0] d;
    logic stat_mode = 1'b0;
    int busy_cnt = 0;
    int n_cmd = 0;
    logic [7:0] cmd_log [64];
    logic [21:0] addr_log [64];
    // commands are latched on the rising write strobe; writes other than 70h while busy are lost
    always @(posedge we_n) begin
        d = dq_wr & {8{dq_wr_en}};
        // status polling stays allowed while the machine is busy
        if (ce_n === 1'b0 && rp_n === 1'b1 && (busy_cnt == 0 || d == 8'h70)) begin
            cmd_log[n_cmd] = d;
            addr_log[n_cmd] = addr;
            n_cmd++;
            stat_mode = (d != 8'hFF);
            if (d == 8'h50)
                flags = 8'h00;
            if (d == 8'hD0 && (prev_cmd == 8'h20 || prev_cmd == 8'h60)) begin
                busy_cnt = BUSY_CYC;
                case (inj)
                    3'h1: flags |= (prev_cmd == 8'h20) ? 8'h02 : 8'h00;
                    3'h2: flags |= 8'h28;
                    3'h3: flags |= 8'h20;
                    3'h4: flags |= 8'h30;
                    default: ;
                endcase
            end else if (d == 8'hD0 || prev_cmd == 8'h20 || prev_cmd == 8'h60) begin
                flags |= 8'h30;
            end
            prev_cmd = d;
        end
    end
    always @(negedge rp_n) begin
        flags = 8'h00;
        busy_cnt = 0;
        stat_mode = 1'b0;
        prev_cmd = 8'hFF;
    end
    always @(posedge pclk) begin
        if (busy_cnt > 0)
            busy_cnt--;
    end
    // low bits scrambled while busy so a premature read cannot pass
    always @* drv = stat_mode ? {busy_cnt == 0, (busy_cnt == 0) ? flags[6:0] : 7'h55} : 8'hA5;
    assign dq_rd = (ce_n === 1'b0 && oe_n === 1'b0 && rp_n === 1'b1) ? drv : ~drv;
    // open drain with pull-up: released when idle or powered down
    assign ind = (rp_n === 1'b1 && busy_cnt != 0) ? 1'b0 : 1'b1;
endmodule

/* File: verif/flash_erase_unlock_sequencer_tb_top.sv */
module flash_erase_unlock_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ce_n, oe_n, we_n, dq_oe, rp_n, ind;
    logic [21:0] fa;
    logic [7:0] dq_o;
    logic [7:0] dq_i;
    logic [2:0] inj = 3'h0;
    logic [31:0] rd;
    int error_cnt = 0;
    int num_checks = 0;
    // per run: control bits, injected fault, final status byte, interrupt status
    logic [3:0] op_ctrl [6] = '{4'h1, 4'h1, 4'h2, 4'h1, 4'h2, 4'h4};
    logic [2:0] op_inj [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [7:0] op_st [6] = '{8'h80, 8'h82, 8'hA8, 8'hA0, 8'hB0, 8'h80};
    logic [3:0] op_irq [6] = '{4'h9, 4'hB, 4'hB, 4'hB, 4'hF, 4'h1};
    always #50 pclk = ~pclk;
    flash_erase_unlock_sequencer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
        .power_down_reset_pin_n(rp_n), .completion_indicator(ind)
    );
    flash_device_model mdl (
        .pclk(pclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_wr(dq_o),
        .dq_wr_en(dq_oe), .rp_n(rp_n), .dq_rd(dq_i), .ind(ind), .inj(inj)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer, read data lands in rd
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer is registered, so look at it before the edge that samples it
        @(negedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                summarize();
            end
            @(negedge pclk);
        end
        rd = prdata;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a sequence, then poll the busy bit until the controller is idle
    task automatic run_op(input logic [3:0] ctrl);
        int n;
        n = 0;
        apb(1'b1, flash_seq_pkg::REG_CTRL, {28'h0, ctrl});
        apb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0);
        check("busy after start", rd[4], 1'b1);
        while (rd[4] !== 1'b0) begin
            n++;
            if (n > 400) begin
                error_cnt++;
                summarize();
            end
            apb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0);
        end
    endtask
    initial begin
        logic [7:0] exp_cmd [$];
        int base;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0);
        check("ctrl after reset", rd, 32'h0);
        check("power pin after reset", rp_n, 1'b1);
        apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
        check("status after reset", rd, 32'h100);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("slave error", pslverr, 1'b0);
        apb(1'b1, flash_seq_pkg::REG_ADDR, 32'h0012_3456);
        apb(1'b1, flash_seq_pkg::REG_IRQ_MASK, 32'hF);
        for (int i = 0; i < 6; i++) begin
            inj <= op_inj[i];
            base = mdl.n_cmd;
            run_op(op_ctrl[i]);
            apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
            check("status byte", rd, {23'h0, 1'b1, op_st[i]});
            apb(1'b0, flash_seq_pkg::REG_IRQ_STATUS, 32'h0);
            check("irq status", rd, {28'h0, op_irq[i]});
            check("irq level", irq, 1'b1);
            exp_cmd = {};
            if (op_ctrl[i][0])
                exp_cmd = {8'h20, 8'hD0};
            if (op_ctrl[i][1])
                exp_cmd = {8'h60, 8'hD0};
            exp_cmd.push_back(8'h70);
            if (op_st[i][6:0] != 7'h00)
                exp_cmd.push_back(8'h50);
            exp_cmd.push_back(8'hFF);
            check("command count", mdl.n_cmd - base, exp_cmd.size());
            foreach (exp_cmd[k])
                check("command", mdl.cmd_log[base + k], exp_cmd[k]);
            if (op_ctrl[i][0]) begin
                check("setup addr", mdl.addr_log[base], 22'h12_3456);
                check("confirm addr", mdl.addr_log[base + 1], 22'h12_3456);
            end
            apb(1'b1, flash_seq_pkg::REG_IRQ_STATUS, 32'hF);
            apb(1'b0, flash_seq_pkg::REG_IRQ_STATUS, 32'h0);
            check("irq status cleared", rd, 32'h0);
            check("irq released", irq, 1'b0);
        end
        // masked completion must not raise the line until unmasked
        apb(1'b1, flash_seq_pkg::REG_IRQ_MASK, 32'h0);
        inj <= 3'h0;
        run_op(4'h4);
        apb(1'b0, flash_seq_pkg::REG_IRQ_STATUS, 32'h0);
        check("masked irq status", rd, 32'h1);
        check("masked irq", irq, 1'b0);
        apb(1'b1, flash_seq_pkg::REG_IRQ_MASK, 32'h1);
        apb(1'b0, flash_seq_pkg::REG_IRQ_MASK, 32'h0);
        check("mask readback", rd, 32'h1);
        check("unmasked irq", irq, 1'b1);
        apb(1'b1, flash_seq_pkg::REG_IRQ_STATUS, 32'h1);
        apb(1'b0, flash_seq_pkg::REG_IRQ_STATUS, 32'h0);
        check("irq after clear", irq, 1'b0);
        // power-down during the erase setup write, so the failing-block fault never reaches the device
        inj <= 3'h3;
        apb(1'b1, flash_seq_pkg::REG_CTRL, 32'h1);
        apb(1'b1, flash_seq_pkg::REG_CTRL, 32'h8);
        apb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0);
        check("ctrl in power-down", rd, 32'h8);
        check("power pin low", rp_n, 1'b0);
        check("indicator released", ind, 1'b1);
        apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
        check("status after abort", rd, 32'h100);
        apb(1'b1, flash_seq_pkg::REG_CTRL, 32'h0);
        apb(1'b0, flash_seq_pkg::REG_CTRL, 32'h0);
        check("power pin restored", rp_n, 1'b1);
        inj <= 3'h0;
        run_op(4'h4);
        apb(1'b0, flash_seq_pkg::REG_STATUS, 32'h0);
        check("flags gone after power-down", rd, 32'h180);
        summarize();
    end
endmodule
